// ---- src/ripple_counter_dividers.sv ----
/*
  Ripple counter family: divide-by-twelve, 4-bit binary and decade variants,
  chosen by a mode register over Avalon-MM. Count and reset pins are sampled
  on clk; external wiring chains output A into the second-stage input.
  Assumes pins are synchronous to clk and a master that honours waitrequest.
*/
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module ripple_counter_dividers (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        count_input_a,
  input  wire logic        divide_by_six_count_input,
  input  wire logic        stage_b_count_input,
  input  wire logic        divide_by_five_count_input,
  input  wire logic        zero_reset_first,
  input  wire logic        zero_reset_second,
  input  wire logic        nine_preset_first,
  input  wire logic        nine_preset_second,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic      [1:0]  response,
  output logic             output_a,
  output logic             output_b,
  output logic             output_c,
  output logic             output_d
);
  stage_if sif ();

  logic        prev_a;
  logic        prev_six;
  logic        prev_b;
  logic        prev_five;
  logic [1:0]  variant;
  logic        soft_a;
  logic        soft_b;
  logic        wrap_seen;
  logic [15:0] falls;
  logic        pin_fall_a;
  logic        pin_fall_b;
  logic        zero_req;
  logic        nine_req;
  logic        hold;
  logic        accept;
  logic        wr_access;
  logic        is_mode;
  logic        is_status;
  logic        is_falls;
  logic        mapped;
  logic [31:0] rd_value;

  // previous pin levels; reset low so a pin resting low gives no edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_a    <= 1'b0;
      prev_six  <= 1'b0;
      prev_b    <= 1'b0;
      prev_five <= 1'b0;
    end else begin
      prev_a    <= count_input_a;
      prev_six  <= divide_by_six_count_input;
      prev_b    <= stage_b_count_input;
      prev_five <= divide_by_five_count_input;
    end
  end

  assign pin_fall_a = prev_a & ~count_input_a;

  // only the second-stage pin of the chosen variant is heard
  always_comb begin
    case (variant)
      ripple_pkg::VAR_TWELVE: begin
        pin_fall_b = prev_six & ~divide_by_six_count_input;
      end
      ripple_pkg::VAR_DECADE: begin
        pin_fall_b = prev_five & ~divide_by_five_count_input;
      end
      default: begin
        pin_fall_b = prev_b & ~stage_b_count_input;
      end
    endcase
  end

  // reset decode: nine preset exists only on the decade variant
  assign zero_req = zero_reset_first & zero_reset_second;
  assign nine_req = (variant == ripple_pkg::VAR_DECADE)
                  & nine_preset_first & nine_preset_second;
  assign hold     = zero_req | nine_req;

  assign sif.clear_all   = zero_req & ~nine_req;
  assign sif.preset_nine = nine_req;
  assign sif.variant     = variant;
  // counting stalls while any reset holds; the driver must release both the zero and the nine request
  assign sif.fall_a = ~hold & (pin_fall_a | soft_a);
  assign sif.fall_b = ~hold & (pin_fall_b | soft_b);

  // A and the section share clear and preset, so both move together
  first_stage u_first (
    .clk   (clk),
    .rst_n (rst_n),
    .sif   (sif)
  );

  second_section u_second (
    .clk   (clk),
    .rst_n (rst_n),
    .sif   (sif)
  );

  // outputs D C B A come straight from the stage flip-flops
  assign output_a = sif.q_a;
  assign output_b = sif.q_sect[0];
  assign output_c = sif.q_sect[1];
  assign output_d = sif.q_sect[2];

  // bus slave: one wait cycle, then the access completes
  assign accept    = (read | write) & waitrequest;
  assign wr_access = write & ~waitrequest;
  assign is_mode   = (address == ripple_pkg::OFS_MODE);
  assign is_status = (address == ripple_pkg::OFS_STATUS);
  assign is_falls  = (address == ripple_pkg::OFS_FALLS);
  assign mapped    = is_mode | is_status | is_falls;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else if (accept) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // variant select; code 3 is refused and the old variant kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      variant <= ripple_pkg::MODE_RESET;
    end else if (wr_access && is_mode && byteenable[0]
                 && writedata[ripple_pkg::MODE_VAR_LSB +: 2] != ripple_pkg::VAR_BAD) begin
      variant <= writedata[ripple_pkg::MODE_VAR_LSB +: 2];
    end
  end

  // software count strobes act like one falling edge each
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_a <= 1'b0;
      soft_b <= 1'b0;
    end else begin
      soft_a <= wr_access & is_mode & byteenable[0] & writedata[ripple_pkg::MODE_SOFT_A];
      soft_b <= wr_access & is_mode & byteenable[0] & writedata[ripple_pkg::MODE_SOFT_B];
    end
  end

  // sticky section wrap, write one to clear; a new wrap beats the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrap_seen <= 1'b0;
    end else if (sif.sect_wrap) begin
      wrap_seen <= 1'b1;
    end else if (wr_access && is_status && byteenable[1]
                 && writedata[ripple_pkg::STAT_WRAP]) begin
      wrap_seen <= 1'b0;
    end
  end

  // accepted first-stage pulses; a write clears, a same-cycle pulse counts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      falls <= ripple_pkg::FALLS_RESET;
    end else if (wr_access && is_falls && byteenable[0]) begin
      falls <= sif.fall_a ? ripple_pkg::FALLS_STEP : ripple_pkg::FALLS_RESET;
    end else if (sif.fall_a) begin
      falls <= falls + ripple_pkg::FALLS_STEP;
    end
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    if (is_mode) begin
      rd_value[ripple_pkg::MODE_VAR_LSB +: 2] = variant;
    end else if (is_status) begin
      rd_value[3:0]                  = {output_d, output_c, output_b, output_a};
      rd_value[ripple_pkg::STAT_ZERO] = zero_req;
      rd_value[ripple_pkg::STAT_NINE] = nine_req;
      rd_value[ripple_pkg::STAT_WRAP] = wrap_seen;
    end else if (is_falls) begin
      rd_value[15:0] = falls;
    end
  end

  // read data and response settle at the accept edge, stand through completion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
      response <= ripple_pkg::RESP_OK;
    end else if (accept) begin
      readdata <= read ? rd_value : 32'h0000_0000;
      response <= mapped ? ripple_pkg::RESP_OK : ripple_pkg::RESP_DECODE;
    end
  end
endmodule

// ---- src/ripple_pkg.sv ----
/*
  Constants for the ripple divider block: variant codes, register offsets,
  field positions, reset values and the counting limits of the second section.
  Assumes a single 10 MHz clock domain and a 32-bit Avalon-MM register port.
*/
package ripple_pkg;
  localparam logic [1:0] VAR_TWELVE   = 2'h0;
  localparam logic [1:0] VAR_SIXTEEN  = 2'h1;
  localparam logic [1:0] VAR_DECADE   = 2'h2;
  localparam logic [1:0] VAR_BAD      = 2'h3;
  localparam logic [1:0] MODE_RESET   = VAR_TWELVE;

  localparam logic [3:0] OFS_MODE     = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h4;
  localparam logic [3:0] OFS_FALLS    = 4'h8;

  localparam int MODE_VAR_LSB   = 0;
  localparam int MODE_SOFT_A    = 4;
  localparam int MODE_SOFT_B    = 5;
  localparam int STAT_ZERO      = 4;
  localparam int STAT_NINE      = 5;
  localparam int STAT_WRAP      = 8;

  localparam logic [2:0]  SECT_RESET   = 3'h0;
  localparam logic [2:0]  SECT_STEP    = 3'h1;
  localparam logic [2:0]  LAST_TWELVE  = 3'h6;
  localparam logic [2:0]  SKIP_TWELVE  = 3'h2;
  localparam logic [2:0]  JUMP_TWELVE  = 3'h4;
  localparam logic [2:0]  LAST_SIXTEEN = 3'h7;
  localparam logic [2:0]  LAST_DECADE  = 3'h4;
  localparam logic [2:0]  NINE_SECT    = 3'h4;
  localparam logic        NINE_A       = 1'h1;
  localparam logic [15:0] FALLS_RESET  = 16'h0000;
  localparam logic [15:0] FALLS_STEP   = 16'h0001;

  localparam logic [1:0] RESP_OK      = 2'h0;
  localparam logic [1:0] RESP_DECODE  = 2'h3;
endpackage

// ---- src/stage_if.sv ----
/*
  Carrier between the top level and its two counting sections.
  Assumes all members are driven in the clk domain of the top level.
*/
`timescale 1ns/1ps
interface stage_if;
  logic       fall_a;
  logic       fall_b;
  logic       clear_all;
  logic       preset_nine;
  logic [1:0] variant;
  logic       q_a;
  logic [2:0] q_sect;
  logic       sect_wrap;
  modport ctrl   (output fall_a, fall_b, clear_all, preset_nine, variant,
                  input  q_a, q_sect, sect_wrap);
  modport first  (input  fall_a, clear_all, preset_nine, output q_a);
  modport second (input  fall_b, clear_all, preset_nine, variant,
                  output q_sect, sect_wrap);
endinterface

// ---- src/first_stage.sv ----
/*
  Flip-flop A: the lone divide-by-two element.
  Assumes count pulses and reset levels arrive as single-cycle decisions.
*/
`timescale 1ns/1ps
module first_stage (
  input  wire logic clk,
  input  wire logic rst_n,
  stage_if.first    sif
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sif.q_a <= 1'b0;
    end else if (sif.clear_all) begin
      sif.q_a <= 1'b0;
    end else if (sif.preset_nine) begin
      sif.q_a <= ripple_pkg::NINE_A;
    end else if (sif.fall_a) begin
      sif.q_a <= ~sif.q_a;
    end
  end
endmodule

// ---- src/second_section.sv ----
/*
  Second section: outputs B, C, D as a divide-by-six, -eight or -five chain.
  Assumes the variant code stays steady while pulses arrive.
*/
`timescale 1ns/1ps
module second_section (
  input  wire logic clk,
  input  wire logic rst_n,
  stage_if.second   sif
);
  logic [2:0] last;
  logic [2:0] next_sect;

  always_comb begin
    last      = ripple_pkg::LAST_SIXTEEN;
    next_sect = sif.q_sect + ripple_pkg::SECT_STEP;
    case (sif.variant)
      ripple_pkg::VAR_TWELVE: begin
        last = ripple_pkg::LAST_TWELVE;
        // mod-3 on C,B then D toggles: C /3, D /6
        if (sif.q_sect == ripple_pkg::SKIP_TWELVE) begin
          next_sect = ripple_pkg::JUMP_TWELVE;
        end
      end
      ripple_pkg::VAR_DECADE: begin
        last = ripple_pkg::LAST_DECADE;
      end
      default: begin
        last = ripple_pkg::LAST_SIXTEEN;
      end
    endcase
    if (sif.q_sect == last) begin
      next_sect = ripple_pkg::SECT_RESET;
    end
  end

  assign sif.sect_wrap = sif.fall_b & ~sif.clear_all & ~sif.preset_nine
                       & (sif.q_sect == last);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sif.q_sect <= ripple_pkg::SECT_RESET;
    end else if (sif.clear_all) begin
      sif.q_sect <= ripple_pkg::SECT_RESET;
    end else if (sif.preset_nine) begin
      sif.q_sect <= ripple_pkg::NINE_SECT;
    end else if (sif.fall_b) begin
      sif.q_sect <= next_sect;
    end
  end
endmodule

// ---- verification/pulse_source.sv ----
/*
  pulse_source: outside logic that makes count pulses and can link output A into
  the second-stage inputs. Assumes bench clk and fire requests one cycle wide.
*/
`timescale 1ns/1ps
module pulse_source (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic fire_a,
  input  wire logic fire_s,
  input  wire logic link,
  input  wire logic link_d,
  input  wire logic q_a,
  input  wire logic q_d,
  output logic      pin_a,
  output logic      pin_s
);
  logic pulse_a;
  logic pulse_s;
  // one high cycle per request, so each request is exactly one fall
  always_ff @(posedge clk) begin
    pulse_a <= rst_n & fire_a;
    pulse_s <= rst_n & fire_s;
  end
  // the link is a plain wire, so the chain adds the ripple delay of the pins
  assign pin_s = link ? q_a : pulse_s;
  // d back into a gives the symmetric divide by ten on the decade variant
  assign pin_a = link_d ? q_d : pulse_a;
endmodule

// ---- verification/ripple_asserts.sv ----
/*
  Checker for the ripple divider pins and bus.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
module ripple_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        count_input_a,
  input wire logic        divide_by_six_count_input,
  input wire logic        stage_b_count_input,
  input wire logic        divide_by_five_count_input,
  input wire logic        zero_reset_first,
  input wire logic        zero_reset_second,
  input wire logic        nine_preset_first,
  input wire logic        nine_preset_second,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [1:0]  response,
  input wire logic        output_a,
  input wire logic        output_b,
  input wire logic        output_c,
  input wire logic        output_d
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] var_q;
  logic       prev_a;
  logic       prev_s;
  logic       sel_s;
  logic       zclr;
  logic       nset;
  logic       mode_wr;
  logic       soft_a_q;
  logic       soft_s_q;
  assign mode_wr = write & !waitrequest & (address == ripple_pkg::OFS_MODE) & byteenable[0];
  assign zclr = zero_reset_first & zero_reset_second;
  assign nset = nine_preset_first & nine_preset_second & (var_q == ripple_pkg::VAR_DECADE);
  assign sel_s = (var_q == ripple_pkg::VAR_TWELVE) ? divide_by_six_count_input :
                 (var_q == ripple_pkg::VAR_DECADE) ? divide_by_five_count_input :
                 stage_b_count_input;
  // shadow of the variant, so preset rules apply to the decade only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      var_q <= ripple_pkg::MODE_RESET;
    end else if (write && !waitrequest && address == ripple_pkg::OFS_MODE && byteenable[0]
                 && writedata[1:0] != ripple_pkg::VAR_BAD) begin
      var_q <= writedata[1:0];
    end
  end
  // software strobes act one cycle after the accepting edge, like a pin fall
  always_ff @(posedge clk) begin
    prev_a   <= rst_n & count_input_a;
    prev_s   <= rst_n & sel_s;
    soft_a_q <= rst_n & mode_wr & writedata[ripple_pkg::MODE_SOFT_A];
    soft_s_q <= rst_n & mode_wr & writedata[ripple_pkg::MODE_SOFT_B];
  end
  a_zero_clear: assert property (zclr && !nset
    |=> {output_d, output_c, output_b, output_a} == 4'h0)
    else $error("zero reset left outputs set");
  a_nine_force: assert property (nset
    |=> {output_d, output_c, output_b, output_a} == 4'h9)
    else $error("nine preset not applied");
  a_a_toggle: assert property (prev_a && !count_input_a && !zclr && !nset
    |=> output_a != $past(output_a))
    else $error("output a missed a count");
  a_a_hold: assert property ($changed(output_a)
    |-> $past((prev_a & !count_input_a) | soft_a_q | zclr | nset))
    else $error("output a moved without cause");
  a_stage_hold: assert property ($changed({output_d, output_c, output_b})
    |-> $past((prev_s & !sel_s) | soft_s_q | zclr | nset))
    else $error("second section moved without cause");
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  a_wait_rest: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_decode_err: assert property ((read || write) && waitrequest && !(address inside {4'h0, 4'h4, 4'h8})
                                 |=> response == ripple_pkg::RESP_DECODE && readdata == 32'h0)
    else $error("unmapped access not refused");
endmodule
bind ripple_counter_dividers ripple_asserts ripple_asserts_inst (.*);

// ---- verification/tb.sv ----
/*
  tb: self-checking bench for the ripple divider block.
  Assumes pulse_source as the outside logic and the bound checker.
*/
`timescale 1ns/1ps
module tb;
  logic        clk = 1'h0, rst_n = 1'h0, fire_a = 1'h0, fire_s = 1'h0, link = 1'h0;
  logic        zero_reset_first = 1'h0, zero_reset_second = 1'h0, pin_a, pin_s;
  logic        nine_preset_first = 1'h0, nine_preset_second = 1'h0;
  logic        read = 1'h0, write = 1'h0, waitrequest, output_a, output_b, output_c, output_d;
  logic [3:0]  address = 4'h0, byteenable = 4'hf;
  logic        link_d = 1'h0;
  logic [3:0]  dcba;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [1:0]  response, rs;
  int          failures, checked;
  // variant, link, A pulses, second pulses, expected D C B A
  logic [23:0] rows [14] = '{24'h01_05_05, 24'h01_06_08, 24'h01_0b_0d, 24'h01_0c_00,
                             24'h00_00_38, 24'h00_01_61, 24'h11_0f_0f, 24'h11_10_00,
                             24'h10_00_7e, 24'h10_01_81, 24'h21_09_09, 24'h21_0a_00,
                             24'h20_01_49, 24'h20_00_50};
  ripple_counter_dividers ripple_counter_dividers_inst (
    .clk(clk), .rst_n(rst_n), .count_input_a(pin_a),
    .divide_by_six_count_input(pin_s), .stage_b_count_input(pin_s),
    .divide_by_five_count_input(pin_s), .zero_reset_first(zero_reset_first),
    .zero_reset_second(zero_reset_second), .nine_preset_first(nine_preset_first),
    .nine_preset_second(nine_preset_second), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .output_a(output_a),
    .output_b(output_b), .output_c(output_c), .output_d(output_d));
  pulse_source pulse_source_inst (.clk(clk), .rst_n(rst_n), .fire_a(fire_a), .fire_s(fire_s),
    .link(link), .link_d(link_d), .q_a(output_a), .q_d(output_d), .pin_a(pin_a),
    .pin_s(pin_s));
  assign dcba = {output_d, output_c, output_b, output_a};
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic summarize();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [3:0] ad, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic [1:0] rsp);
    @(posedge clk);
    address   <= ad;
    write     <= wr;
    read      <= !wr;
    writedata <= wd;
    // only the watchdog ends a wait that never completes
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'h0);
    rdat = readdata;
    rsp = response;
    read  <= 1'h0;
    write <= 1'h0;
  endtask
  // hold the zero reset level, long enough to swallow a ripple from a link
  task automatic zr(input logic z);
    @(posedge clk);
    zero_reset_first  <= z;
    zero_reset_second <= z;
    repeat (3) @(posedge clk);
  endtask
  task automatic pulses(input int na, input int ns);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      fire_a <= (i < na);
      fire_s <= (i < ns);
      @(posedge clk);
      fire_a <= 1'h0;
      fire_s <= 1'h0;
      repeat (2) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    chk({waitrequest, output_d, output_c, output_b, output_a}, 32'h10);
    foreach (rows[k]) begin
      zr(1'h1);
      chk(dcba, 32'h0);
      link <= rows[k][16];
      zr(1'h0);
      bus(ripple_pkg::OFS_MODE, 1'h1, {30'h0, rows[k][21:20]}, rd, rs);
      pulses(rows[k][15:8], rows[k][7:4]);
      chk(dcba, rows[k][3:0]);
    end
    nine_preset_first  <= 1'h1;
    nine_preset_second <= 1'h1;
    zr(1'h1);
    pulses(2, 2);
    chk(dcba, 32'h9);
    nine_preset_first <= 1'h0;
    zr(1'h1);
    pulses(1, 0);
    chk(dcba, 32'h0);
    zr(1'h0);
    pulses(1, 1);
    chk(dcba, 32'h3);
    bus(ripple_pkg::OFS_STATUS, 1'h0, 32'h0, rd, rs);
    chk(rd[3:0], 32'h3);
    bus(ripple_pkg::OFS_MODE, 1'h1, 32'h3, rd, rs);
    bus(ripple_pkg::OFS_MODE, 1'h0, 32'h0, rd, rs);
    chk(rd[1:0], {30'h0, ripple_pkg::VAR_DECADE});
    bus(4'hc, 1'h0, 32'h0, rd, rs);
    chk({rs, rd[29:0]}, {ripple_pkg::RESP_DECODE, 30'h0});
    // d fed back into a: a toggles once per five second-stage counts
    zr(1'h1);
    link_d <= 1'h1;
    zr(1'h0);
    pulses(0, 5);
    chk(dcba, 32'h1);
    pulses(0, 7);
    chk(dcba, 32'h4);
    link_d <= 1'h0;
    // software strobes step each section once; wrap flag sticks until cleared
    bus(ripple_pkg::OFS_FALLS, 1'h1, 32'h0, rd, rs);
    bus(ripple_pkg::OFS_MODE, 1'h1, 32'h32, rd, rs);
    bus(ripple_pkg::OFS_STATUS, 1'h0, 32'h0, rd, rs);
    chk(rd, 32'h107);
    bus(ripple_pkg::OFS_STATUS, 1'h1, 32'h100, rd, rs);
    bus(ripple_pkg::OFS_STATUS, 1'h0, 32'h0, rd, rs);
    chk(rd, 32'h7);
    bus(ripple_pkg::OFS_MODE, 1'h1, 32'h22, rd, rs);
    bus(ripple_pkg::OFS_MODE, 1'h1, 32'h22, rd, rs);
    bus(ripple_pkg::OFS_STATUS, 1'h0, 32'h0, rd, rs);
    chk(rd, 32'h101);
    bus(ripple_pkg::OFS_FALLS, 1'h0, 32'h0, rd, rs);
    chk(rd, 32'h1);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
